// ### include/art_pkg.sv
// Operation
// - timer is 16 bits made of low and high 8-bit halves.
// - split-mode bit 3 selects one 16-bit or two 8-bit reload timers.
// - clocks are system clock, system clock /12, or synchronised external /8.
// - 16-bit rollover loads reload pair and sets high overflow flag.
// - 16-bit mode interrupts on every full overflow when enabled.
// - 16-bit mode with low enable also interrupts on low byte rollover.
// - split mode halves count and reload from their own reload bytes.
// - split mode run bit gates only the high half; low always runs.
// - per-half fast select picks system clock, else /12 or external /8.
// - split mode sets each half's overflow flag on its own rollover.
// - split mode interrupts on high overflow, or either with low enable.
// - overflow flags stay set until software writes zero.
// - capture mode counts on system clock or /12 by low select.
// - capture event on each falling edge of external oscillator /8.
// - capture copies counter into reload pair and sets high flag.
// - control bit 4 enables capture mode.
// - all control fields and flags reset to zero.
package art_pkg;

   // ----------------------------------------------------------------
   // register map, byte addresses on the bus
   // ----------------------------------------------------------------
   localparam int         ADDR_W      = 8;
   localparam logic [7:0] OFS_CTRL    = 8'h00;
   localparam logic [7:0] OFS_CNT_LO  = 8'h04;
   localparam logic [7:0] OFS_CNT_HI  = 8'h08;
   localparam logic [7:0] OFS_RLD_LO  = 8'h0C;
   localparam logic [7:0] OFS_RLD_HI  = 8'h10;
   localparam logic [7:0] OFS_CLKCTL  = 8'h14;
   localparam logic [7:0] OFS_IEN     = 8'h18;

   // ----------------------------------------------------------------
   // fields and reset values
   // ----------------------------------------------------------------
   localparam int         IEN_BIT     = 0;
   localparam logic [7:0] BYTE_ZERO   = 8'h00;
   localparam logic [7:0] BYTE_MAX    = 8'hFF;
   localparam logic [7:0] CTRL_RESET  = 8'h00;
   localparam logic [7:0] CLK_RESET   = 8'h00;
   localparam int         SYS_DIV     = 12;
   localparam int         EXT_DIV_W   = 3;

   typedef struct packed {
      logic high_overflow_flag;
      logic low_overflow_flag;
      logic low_overflow_irq_enable;
      logic capture_enable;
      logic split_mode_select;
      logic run_control;
      logic unused;
      logic external_clock_select;
   } art_ctrl_type;

   typedef struct packed {
      logic       high_half_fast_clock_select;
      logic       low_half_fast_clock_select;
      logic [5:0] unused;
   } art_clkctl_type;

endpackage : art_pkg

// ### design/art_timer.sv
module art_timer
   import art_pkg::*;
#(
   parameter int PRESCALE = SYS_DIV
)(
   input  wire logic              MCLK,
   input  wire logic              RST,
   input  wire logic              PSEL,
   input  wire logic              PENABLE,
   input  wire logic              PWRITE,
   input  wire logic [ADDR_W-1:0] PADDR,
   input  wire logic [31:0]       PWDATA,
   output logic      [31:0]       PRDATA,
   output logic                   PREADY,
   output logic                   PSLVERR,
   input  wire logic              EXT_OSC,
   output logic                   TIMER_IRQ
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   art_ctrl_type        ctrl_reg,    ctrl_next;
   art_clkctl_type      clk_reg,     clk_next;
   logic                ien_reg,     ien_next;
   logic [7:0]          lo_reg,      lo_next;
   logic [7:0]          hi_reg,      hi_next;
   logic [7:0]          rld_lo_reg,  rld_lo_next;
   logic [7:0]          rld_hi_reg,  rld_hi_next;
   logic                irq_reg,     irq_next;
   logic [3:0]          div_reg,     div_next;
   logic                sync1_reg,   sync2_reg;
   logic                osc_prev_reg;
   logic [EXT_DIV_W-1:0] ext_cnt_reg, ext_cnt_next;
   logic                ext8_prev_reg;
   logic [31:0]         rdata_reg,   rdata_next;

   logic                tick12;
   logic                ext8;
   logic                ext_tick;
   logic                ext_fall;
   logic                tick_l;
   logic                tick_h;
   logic                wr;
   logic                mapped;
   logic                set_h;
   logic                set_l;
   logic [15:0]         cnt;
   logic [15:0]         rld;
   logic [31:0]         rd_mux;

   assign cnt = {hi_reg, lo_reg};
   assign rld = {rld_hi_reg, rld_lo_reg};

   // ----------------------------------------------------------------
   // clock sources
   // ----------------------------------------------------------------
   // the external divider runs on the synchronised oscillator, so the
   // measured clock must stay well below half the system clock
   always_comb begin
      div_next     = (div_reg == 4'(PRESCALE - 1)) ? 4'h0 : 4'(div_reg + 4'h1);
      ext_cnt_next = ext_cnt_reg;
      if (sync2_reg && !osc_prev_reg) begin
         ext_cnt_next = EXT_DIV_W'(ext_cnt_reg + 1'b1);
      end
   end

   assign tick12   = (div_reg == 4'(PRESCALE - 1));
   assign ext8     = ext_cnt_reg[EXT_DIV_W-1];
   assign ext_tick = ext8 && !ext8_prev_reg;
   assign ext_fall = !ext8 && ext8_prev_reg;

   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         div_reg       <= 4'h0;
         sync1_reg     <= 1'b0;
         sync2_reg     <= 1'b0;
         osc_prev_reg  <= 1'b0;
         ext_cnt_reg   <= '0;
         ext8_prev_reg <= 1'b0;
      end else begin
         div_reg       <= div_next;
         sync1_reg     <= EXT_OSC;
         sync2_reg     <= sync1_reg;
         osc_prev_reg  <= sync2_reg;
         ext_cnt_reg   <= ext_cnt_next;
         ext8_prev_reg <= ext8;
      end
   end

   // capture mode never counts the low half or the 16-bit counter on the external source it measures
   always_comb begin
      if (ctrl_reg.capture_enable) begin
         tick_l = clk_reg.low_half_fast_clock_select | tick12;
      end else begin
         tick_l = clk_reg.low_half_fast_clock_select |
                  (ctrl_reg.external_clock_select ? ext_tick : tick12);
      end
      tick_h = clk_reg.high_half_fast_clock_select |
               (ctrl_reg.external_clock_select ? ext_tick : tick12);
   end

   // ----------------------------------------------------------------
   // bus decode
   // ----------------------------------------------------------------
   assign wr = PSEL && PENABLE && PWRITE;

   always_comb begin
      mapped = 1'b1;
      rd_mux = 32'h0;
      unique case (PADDR)
         OFS_CTRL:   rd_mux = {24'h0, ctrl_reg.high_overflow_flag, ctrl_reg.low_overflow_flag,
                               ctrl_reg.low_overflow_irq_enable, ctrl_reg.capture_enable,
                               ctrl_reg.split_mode_select, ctrl_reg.run_control, 1'b0,
                               ctrl_reg.external_clock_select};
         OFS_CNT_LO: rd_mux = {24'h0, lo_reg};
         OFS_CNT_HI: rd_mux = {24'h0, hi_reg};
         OFS_RLD_LO: rd_mux = {24'h0, rld_lo_reg};
         OFS_RLD_HI: rd_mux = {24'h0, rld_hi_reg};
         OFS_CLKCTL: rd_mux = {24'h0, clk_reg.high_half_fast_clock_select,
                               clk_reg.low_half_fast_clock_select, 6'h0};
         OFS_IEN:    rd_mux = {31'h0, ien_reg};
         default:    mapped = 1'b0;
      endcase
   end

   // read data is caught in the setup cycle, one edge before it is taken
   always_comb begin
      rdata_next = rdata_reg;
      if (PSEL && !PENABLE) begin
         rdata_next = rd_mux;
      end
   end

   assign PREADY  = 1'b1;
   assign PSLVERR = PSEL && PENABLE && !mapped;
   assign PRDATA  = rdata_reg;

   // ----------------------------------------------------------------
   // counters, reloads, flags
   // ----------------------------------------------------------------
   always_comb begin
      ctrl_next   = ctrl_reg;
      clk_next    = clk_reg;
      ien_next    = ien_reg;
      lo_next     = lo_reg;
      hi_next     = hi_reg;
      rld_lo_next = rld_lo_reg;
      rld_hi_next = rld_hi_reg;
      set_h       = 1'b0;
      set_l       = 1'b0;

      if (ctrl_reg.split_mode_select) begin
         if (tick_l) begin
            if (lo_reg == BYTE_MAX) begin
               lo_next = rld_lo_reg;
               set_l   = 1'b1;
            end else begin
               lo_next = 8'(lo_reg + 8'h01);
            end
         end
         if (ctrl_reg.run_control && tick_h) begin
            if (hi_reg == BYTE_MAX) begin
               hi_next = rld_hi_reg;
               set_h   = 1'b1;
            end else begin
               hi_next = 8'(hi_reg + 8'h01);
            end
         end
      end else if (ctrl_reg.run_control && tick_l) begin
         if (cnt == 16'hFFFF) begin
            {hi_next, lo_next} = rld;
            set_h = 1'b1;
         end else begin
            {hi_next, lo_next} = 16'(cnt + 16'h0001);
         end
         set_l = (lo_reg == BYTE_MAX);
      end

      if (ctrl_reg.capture_enable && ext_fall) begin
         {rld_hi_next, rld_lo_next} = cnt;
         set_h = 1'b1;
      end

      // software writes win over counting, flag sets win over clears
      if (wr) begin
         unique case (PADDR)
            OFS_CTRL:   ctrl_next = art_ctrl_type'({PWDATA[7:2], 1'b0, PWDATA[0]});
            OFS_CNT_LO: lo_next   = PWDATA[7:0];
            OFS_CNT_HI: hi_next   = PWDATA[7:0];
            OFS_RLD_LO: if (!(ctrl_reg.capture_enable && ext_fall)) rld_lo_next = PWDATA[7:0];
            OFS_RLD_HI: if (!(ctrl_reg.capture_enable && ext_fall)) rld_hi_next = PWDATA[7:0];
            OFS_CLKCTL: clk_next  = art_clkctl_type'({PWDATA[7:6], 6'h0});
            OFS_IEN:    ien_next  = PWDATA[IEN_BIT];
            default:    ;
         endcase
      end
      ctrl_next.high_overflow_flag = ctrl_next.high_overflow_flag | set_h;
      ctrl_next.low_overflow_flag  = ctrl_next.low_overflow_flag | set_l;

      irq_next = ien_next & (ctrl_next.high_overflow_flag |
                 (ctrl_next.low_overflow_irq_enable & ctrl_next.low_overflow_flag));
   end

   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         ctrl_reg   <= art_ctrl_type'(CTRL_RESET);
         clk_reg    <= art_clkctl_type'(CLK_RESET);
         ien_reg    <= 1'b0;
         lo_reg     <= BYTE_ZERO;
         hi_reg     <= BYTE_ZERO;
         rld_lo_reg <= BYTE_ZERO;
         rld_hi_reg <= BYTE_ZERO;
         irq_reg    <= 1'b0;
         rdata_reg  <= 32'h0;
      end else begin
         ctrl_reg   <= ctrl_next;
         clk_reg    <= clk_next;
         ien_reg    <= ien_next;
         lo_reg     <= lo_next;
         hi_reg     <= hi_next;
         rld_lo_reg <= rld_lo_next;
         rld_hi_reg <= rld_hi_next;
         irq_reg    <= irq_next;
         rdata_reg  <= rdata_next;
      end
   end

   assign TIMER_IRQ = irq_reg;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (RST);

   full_reload_a: assert property (
      !ctrl_reg.split_mode_select && ctrl_reg.run_control && tick_l && cnt == 16'hFFFF && !wr
      && !(ctrl_reg.capture_enable && ext_fall)
      |=> cnt == $past(rld) && ctrl_reg.high_overflow_flag)
      else $error("16-bit rollover did not reload or flag");

   count_step_a: assert property (
      !ctrl_reg.split_mode_select && ctrl_reg.run_control && tick_l && cnt != 16'hFFFF && !wr
      |=> cnt == 16'($past(cnt) + 16'h0001))
      else $error("16-bit counter did not step by one");

   split_reload_a: assert property (
      ctrl_reg.split_mode_select && tick_l && lo_reg == BYTE_MAX && !wr
      |=> lo_reg == $past(rld_lo_reg) && ctrl_reg.low_overflow_flag)
      else $error("low half did not reload from its byte");

   low_free_a: assert property (
      ctrl_reg.split_mode_select && !ctrl_reg.run_control && tick_l && lo_reg != BYTE_MAX && !wr
      |=> lo_reg == 8'($past(lo_reg) + 8'h01))
      else $error("low half stopped with run control clear");

   high_hold_a: assert property (
      ctrl_reg.split_mode_select && !ctrl_reg.run_control && !wr |=> hi_reg == $past(hi_reg))
      else $error("high half moved while stopped");

   slow_clock_a: assert property (
      ctrl_reg.split_mode_select && !clk_reg.low_half_fast_clock_select
      && !ctrl_reg.external_clock_select && !tick12 && !wr |=> lo_reg == $past(lo_reg))
      else $error("low half counted between divide-by-12 ticks");

   flag_sticky_a: assert property (
      ctrl_reg.high_overflow_flag && ctrl_reg.low_overflow_flag && !(wr && PADDR == OFS_CTRL)
      |=> ctrl_reg.high_overflow_flag && ctrl_reg.low_overflow_flag)
      else $error("overflow flag cleared by hardware");

   capture_copy_a: assert property (
      ctrl_reg.capture_enable && ext_fall && !(wr && PADDR == OFS_CTRL)
      |=> rld == $past(cnt) && ctrl_reg.high_overflow_flag)
      else $error("capture did not copy counter");

   irq_level_a: assert property (
      TIMER_IRQ == (ien_reg && (ctrl_reg.high_overflow_flag ||
                   (ctrl_reg.low_overflow_irq_enable && ctrl_reg.low_overflow_flag))))
      else $error("interrupt request disagrees with flags");

   reset_clear_a: assert property (disable iff (1'b0)
      RST |=> ctrl_reg == art_ctrl_type'(CTRL_RESET) && !TIMER_IRQ)
      else $error("control not cleared by reset");

   split_ovf_c:  cover property (ctrl_reg.split_mode_select && set_h && set_l);
   full_ovf_c:   cover property (!ctrl_reg.split_mode_select && set_h && ctrl_reg.run_control);
   capture_c:    cover property (ctrl_reg.capture_enable && ext_fall ##[1:200] ext_fall);
   irq_c:        cover property ($rose(TIMER_IRQ));

endmodule : art_timer

// ### testbench/art_osc_model.sv
module art_osc_model #(
   parameter int HALF = 24
)(
   input  wire logic clk,
   input  wire logic en,
   output logic      osc
);
   timeunit 1ns;
   timeprecision 1ps;

   int cnt_reg;

   // ----------------------------------------------------------------
   // measured oscillator
   // ----------------------------------------------------------------
   // stands low while disabled; half period well above the synchroniser limit
   always_ff @(posedge clk) begin
      if (!en) begin
         cnt_reg <= 0;
         osc     <= 1'b0;
      end else if (cnt_reg == HALF - 1) begin
         cnt_reg <= 0;
         osc     <= ~osc;
      end else begin
         cnt_reg <= cnt_reg + 1;
      end
   end
endmodule : art_osc_model

// ### testbench/art_timer_tb_top.sv
module art_timer_tb_top;
   import art_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;

   localparam int GAP = 20;

   logic              mclk, rst, psel, penable, pwrite, pready, pslverr, osc_en, ext_osc, timer_irq, e;
   logic [ADDR_W-1:0] paddr;
   logic [31:0]       pwdata, prdata, q;
   logic [15:0]       v1, v2;
   int                n_errors, n_tests, cyc, d;

   art_timer u_art_timer (.MCLK(mclk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
      .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .EXT_OSC(ext_osc), .TIMER_IRQ(timer_irq));
   art_osc_model u_art_osc_model (.clk(mclk), .en(osc_en), .osc(ext_osc));

   // ----------------------------------------------------------------
   // clock, timeout, report
   // ----------------------------------------------------------------
   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end

   always @(posedge mclk) begin
      cyc++;
      if (cyc == 30000) begin
         n_errors++;
         test_done();
      end
   end

   task test_done();
      $display("Checks %0d, errors %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : test_done

   task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_errors++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   // ----------------------------------------------------------------
   // apb master
   // ----------------------------------------------------------------
   task xfer(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rv);
      @(posedge mclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= wd;
      @(posedge mclk);
      penable <= 1'b1;
      @(posedge mclk);
      while (pready !== 1'b1) @(posedge mclk);
      rv = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : xfer

   task wr(input logic [7:0] a, input logic [31:0] wd);
      logic [31:0] t;
      xfer(1'b1, a, wd, t);
   endtask : wr

   task rd(input logic [7:0] a, output logic [31:0] rv);
      xfer(1'b0, a, 32'h0, rv);
   endtask : rd

   task ld(input logic [15:0] c, input logic [15:0] r);
      wr(OFS_CNT_LO, {24'h0, c[7:0]});
      wr(OFS_CNT_HI, {24'h0, c[15:8]});
      wr(OFS_RLD_LO, {24'h0, r[7:0]});
      wr(OFS_RLD_HI, {24'h0, r[15:8]});
   endtask : ld

   // same GAP for every run that uses d, so the measured tick count d carries over
   // flags are read back first: a plain stop write would clear them
   task run(input logic [31:0] on, input logic [31:0] off, input int gap);
      logic [31:0] f;
      wr(OFS_CTRL, on);
      repeat (gap) @(posedge mclk);
      rd(OFS_CTRL, f);
      wr(OFS_CTRL, (f & 32'hC0) | off);
   endtask : run

   task cnt(output logic [31:0] v);
      logic [31:0] lo, hi;
      rd(OFS_CNT_LO, lo);
      rd(OFS_CNT_HI, hi);
      v = {16'h0, hi[7:0], lo[7:0]};
   endtask : cnt

   task cap(output logic [15:0] v);
      int i;
      wr(OFS_CTRL, 32'h14);
      q = 32'h0;
      i = 0;
      while (q[7] !== 1'b1 && i < 200) begin
         rd(OFS_CTRL, q);
         i++;
      end
      rd(OFS_RLD_LO, q);
      v[7:0] = q[7:0];
      rd(OFS_RLD_HI, q);
      v[15:8] = q[7:0];
   endtask : cap

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      osc_en = 1'b0;
      n_errors = 0;
      n_tests = 0;
      cyc = 0;
      repeat (6) @(posedge mclk);
      rst <= 1'b0;
      for (int a = 0; a <= 24; a += 4) begin
         rd(a[7:0], q);
         check("reset value", q, 32'h0);
         check("mapped error", 32'(e), 32'h0);
      end
      rd(8'h1C, q);
      check("unmapped error", 32'(e), 32'h1);
      check("unmapped data", q, 32'h0);
      for (int a = 4; a <= 16; a += 4) begin
         wr(a[7:0], 32'hA0 + a);
         rd(a[7:0], q);
         check("readback", q, 32'hA0 + a);
      end
      wr(OFS_CTRL, 32'h02);
      rd(OFS_CTRL, q);
      check("ctrl unused bit", q, 32'h0);
      wr(OFS_CLKCTL, 32'hC0);
      wr(OFS_IEN, 32'h1);
      ld(16'h0010, 16'h1200);
      run(32'h04, 32'h00, GAP);
      cnt(q);
      d = int'(q) - 16;
      check("tick window", 32'(d >= GAP && d <= GAP + 6), 32'h1);
      ld(16'hFFF8, 16'h1200);
      run(32'h04, 32'h00, GAP);
      cnt(q);
      check("16-bit reload", q, 32'(32'h1200 + d - 8));
      rd(OFS_CTRL, q);
      check("16-bit flags", q, 32'hC0);
      check("16-bit irq", 32'(timer_irq), 32'h1);
      repeat (50) @(posedge mclk);
      rd(OFS_CTRL, q);
      check("flags held", q, 32'hC0);
      wr(OFS_CTRL, 32'h00);
      rd(OFS_CTRL, q);
      check("flags cleared", q, 32'h0);
      check("irq cleared", 32'(timer_irq), 32'h0);
      ld(16'h00F8, 16'h0000);
      run(32'h24, 32'h20, GAP);
      cnt(q);
      check("low carry", q, 32'(32'h0100 + d - 8));
      rd(OFS_CTRL, q);
      check("low byte flag", q, 32'h60);
      check("low byte irq", 32'(timer_irq), 32'h1);
      ld(16'h55F0, 16'h3380);
      run(32'h08, 32'h00, GAP);
      cnt(q);
      check("split low only", q, {16'h0, 8'h55, 8'(8'h80 + d - 16)});
      rd(OFS_CTRL, q);
      check("split low flag", q, 32'h40);
      check("split low no irq", 32'(timer_irq), 32'h0);
      wr(OFS_CTRL, 32'h60);
      @(posedge mclk);
      check("split low irq", 32'(timer_irq), 32'h1);
      wr(OFS_CTRL, 32'h00);
      ld(16'hFE10, 16'h3380);
      run(32'h0C, 32'h00, GAP);
      cnt(q);
      check("split both", q, {16'h0, 8'(8'h33 + d - 2), 8'(8'h10 + d)});
      rd(OFS_CTRL, q);
      check("split high flag", q, 32'h80);
      check("split high irq", 32'(timer_irq), 32'h1);
      // capture kept in 16-bit mode on a fast timer clock
      ld(16'h0000, 16'h0000);
      osc_en <= 1'b1;
      cap(v1);
      cap(v2);
      check("capture fast", 32'(v2 - v1), 32'd384);
      wr(OFS_CLKCTL, 32'h00);
      cap(v1);
      cap(v2);
      check("capture div12", 32'(v2 - v1), 32'd32);
      wr(OFS_CTRL, 32'h04);
      ld(16'h0000, 16'h0000);
      repeat (800) @(posedge mclk);
      rd(OFS_CTRL, q);
      check("capture off", q, 32'h04);
      rd(OFS_RLD_LO, q);
      check("capture off reload", q, 32'h0);
      wr(OFS_CTRL, 32'h00);
      ld(16'h0000, 16'h0000);
      run(32'h05, 32'h00, 1536);
      cnt(q);
      check("external ticks", 32'(q >= 3 && q <= 5), 32'h1);
      test_done();
   end
endmodule : art_timer_tb_top
